// [logic/data_access_hint_policy.sv]
// Data access hint policy: discard, pipeline and fill decisions
// Assumes all inputs come from core logic on ref_clk
//
// Operation
// - Discard field 0: prefetch completes, faults only if of faulting kind
// - Discard field 1: drop prefetch on translation buffer miss
// - Discard field 2: drop on translation buffer or mid-level miss
// - Discard field 3: also drop on any xlat miss or queue pressure
// - Count discards by cause: xlat, mid-level, first-level xlat
// - Pipe bit 0: xlat-missing prefetch walks and queues without stall
// - Pipe bit 0: missing speculative load defers when defer_allowed, else uses stall; count mid-level deferrals
// - Pipe bit 1: xlat-missing prefetch stalls pipeline until walk done
// - Pipe bit 1: load not deferred, uses stall; suppressions counted only on xlat miss
// - Fill bit exclusive: fill exclusive when no other cache holds line
// - Fill bit shared: fill shared; count shared fills when no other cache holds line
// - Event capture records hint values of the captured access
// - Legacy temporal hints select hint registers 0 to 3
// - Defaults: normal discard, exclusive; 0-3 block, 4-7 defer
// - Locality and prefetcher defaults per register as tabled
// - Eleven hint bits per register; upper bits reserved, read zero
// - Call or interruption pushes default frame; return pops it
`include "hint_defs.svh"
`default_nettype none

module data_access_hint_policy
  import hint_pkg::*;
#(
  parameter int AW = `ADDR_W,
  parameter int CW = `CNT_W,
  parameter int DEPTH = `STACK_DEPTH
)
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic hint_wr_en,
  input wire logic [2:0] hint_wr_idx,
  input wire logic [`HINT_SW_W-1:0] hint_wr_data,
  input wire logic [2:0] hint_rd_idx,
  output logic [`HINT_SW_W-1:0] hint_rd_data_r,
  input wire logic call_push,
  input wire logic ret_pop,
  input wire logic ctx_flush,
  output logic [$clog2(DEPTH):0] frame_count,
  input wire logic acc_valid,
  output logic acc_ready,
  input wire acc_kind_t acc_kind,
  input wire logic acc_legacy,
  input wire logic [1:0] acc_temporal,
  input wire logic [2:0] acc_hint_idx,
  input wire logic [AW-1:0] acc_addr,
  input wire logic acc_fault,
  input wire logic acc_fault_kind,
  input wire logic capture_sel,
  input wire logic xlat_miss,
  input wire logic first_xlat_miss,
  input wire logic l2_miss,
  input wire logic pfq_near_full,
  input wire logic defer_allowed,
  input wire logic llc_fill,
  input wire logic other_cache_holds,
  input wire logic walk_done,
  input wire logic load_data_ret,
  output logic pf_discard_r,
  output logic pf_issue_r,
  output logic pf_enqueue_r,
  output logic pf_fault_r,
  output logic walk_start_r,
  output logic pipe_stall,
  output logic spec_defer_r,
  output logic use_stall,
  output logic fill_excl_r,
  output logic fill_shared_r,
  output logic cap_valid_r,
  output logic [AW-1:0] cap_addr_r,
  output hint_t cap_hint_r,
  output logic [2:0] cap_idx_r,
  output logic [CW-1:0] cnt_discard_xlat_miss,
  output logic [CW-1:0] cnt_discard_l2_miss,
  output logic [CW-1:0] cnt_discard_first_xlat_miss,
  output logic [CW-1:0] cnt_l2_defer,
  output logic [CW-1:0] cnt_spec_load_stalled,
  output logic [CW-1:0] cnt_shared_fill
);

  hint_evt_if evt ();

  pipe_state_t state_r;
  pipe_state_t state_nxt;
  hint_t hint;
  hint_t sw_hint;
  logic [2:0] sel_idx;
  logic [`NUM_EV-1:0][CW-1:0] counts;
  prefetch_discard_field_t discard_mode;
  logic pipe_block;
  logic bias_shared;
  logic take;
  logic is_pf;
  logic is_ld;
  logic is_rd;
  logic d_xlat;
  logic d_l2;
  logic d_first;
  logic d_queue;
  logic discard;
  logic pf_go;
  logic pf_walk;
  logic pf_block;
  logic ld_miss;
  logic ld_defer;
  logic ld_block;
  logic fill_go;

  // Legacy temporal hints map onto registers 0 to 3
  assign sel_idx = acc_legacy ? {1'b0, acc_temporal} : acc_hint_idx;

  hint_stack #(
    .DEPTH(DEPTH)
  ) u_stack (
    .ref_clk(ref_clk),
    .srst(srst),
    .push(call_push),
    .pop(ret_pop),
    .flush(ctx_flush),
    .wr_en(hint_wr_en),
    .wr_idx(hint_wr_idx),
    .wr_data(hint_wr_data[`HINT_W-1:0]),
    .a_idx(sel_idx),
    .a_hint(hint),
    .b_idx(hint_rd_idx),
    .b_hint(sw_hint),
    .frames(frame_count)
  );

  hint_counters #(
    .CW(CW)
  ) u_cnt (
    .ref_clk(ref_clk),
    .srst(srst),
    .evt(evt),
    .count_r(counts)
  );

  assign cnt_discard_xlat_miss = counts[`EV_DISC_XLAT];
  assign cnt_discard_l2_miss = counts[`EV_DISC_L2];
  assign cnt_discard_first_xlat_miss = counts[`EV_DISC_FIRST];
  assign cnt_l2_defer = counts[`EV_L2_DEFER];
  assign cnt_spec_load_stalled = counts[`EV_LOAD_STALL];
  assign cnt_shared_fill = counts[`EV_SHARED_FILL];

  // Field decode of the selected hint
  assign discard_mode = prefetch_discard_field_t'(hint[`DROP_MSB:`DROP_LSB]);
  assign pipe_block = hint[`PIPE_BIT];
  assign bias_shared = hint[`BIAS_BIT];

  assign acc_ready = (state_r == ST_IDLE);
  assign take = acc_valid && acc_ready;
  assign is_pf = take && (acc_kind == ACC_PREFETCH);
  assign is_ld = take && (acc_kind == ACC_SPEC_LOAD);
  assign is_rd = take && (acc_kind == ACC_DATA_READ);

  // Discard causes, each but queue pressure counted once by its first cause
  assign d_xlat = (discard_mode != DISCARD_NORMAL) && xlat_miss;
  assign d_l2 = discard_mode[1] && l2_miss && !xlat_miss;
  assign d_first = (discard_mode == DISCARD_ANY) && first_xlat_miss
                   && !xlat_miss && !l2_miss;
  assign d_queue = (discard_mode == DISCARD_ANY) && pfq_near_full;
  assign discard = is_pf && (d_xlat || d_l2 || d_first || d_queue);

  assign pf_go = is_pf && !discard;
  assign pf_walk = pf_go && xlat_miss;
  assign pf_block = pf_walk && pipe_block;

  assign ld_miss = is_ld && (xlat_miss || l2_miss);
  assign ld_defer = ld_miss && !pipe_block && defer_allowed;
  assign ld_block = ld_miss && !ld_defer;

  assign fill_go = is_rd && llc_fill;

  assign evt.ev[`EV_DISC_XLAT] = is_pf && d_xlat;
  assign evt.ev[`EV_DISC_L2] = is_pf && d_l2;
  assign evt.ev[`EV_DISC_FIRST] = is_pf && d_first;
  assign evt.ev[`EV_L2_DEFER] = ld_defer && l2_miss;
  assign evt.ev[`EV_LOAD_STALL] = ld_miss && pipe_block && xlat_miss;
  assign evt.ev[`EV_SHARED_FILL] = fill_go && bias_shared && !other_cache_holds;

  assign pipe_stall = (state_r == ST_WALK);
  assign use_stall = (state_r == ST_USE);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (pf_block)
          state_nxt = ST_WALK;
        else if (ld_block)
          state_nxt = ST_USE;
      end
      ST_WALK:
      begin
        if (walk_done)
          state_nxt = ST_IDLE;
      end
      ST_USE:
      begin
        if (load_data_ret)
          state_nxt = ST_IDLE;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Per-access decisions, one cycle after the access is taken
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pf_discard_r <= 1'b0;
      pf_issue_r <= 1'b0;
      pf_enqueue_r <= 1'b0;
      pf_fault_r <= 1'b0;
      walk_start_r <= 1'b0;
      spec_defer_r <= 1'b0;
      fill_excl_r <= 1'b0;
      fill_shared_r <= 1'b0;
    end
    else
    begin
      pf_discard_r <= discard;
      pf_issue_r <= pf_go;
      pf_fault_r <= pf_go && acc_fault && acc_fault_kind;
      walk_start_r <= pf_walk;
      pf_enqueue_r <= pf_walk && !pipe_block;
      spec_defer_r <= ld_defer;
      fill_excl_r <= fill_go && !bias_shared && !other_cache_holds;
      fill_shared_r <= fill_go && (bias_shared || other_cache_holds);
    end
  end

  // Event address capture with the hint that applied
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cap_valid_r <= 1'b0;
      cap_addr_r <= '0;
      cap_hint_r <= '0;
      cap_idx_r <= 3'h0;
    end
    else
    begin
      cap_valid_r <= take && capture_sel;
      if (take && capture_sel)
      begin
        cap_addr_r <= acc_addr;
        cap_hint_r <= hint;
        cap_idx_r <= sel_idx;
      end
    end
  end

  // Software read; reserved upper bits read zero
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      hint_rd_data_r <= '0;
    else
      hint_rd_data_r <= {{(`HINT_SW_W-`HINT_W){1'b0}}, sw_hint};
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  sequence s_pf;
    acc_valid && acc_ready && acc_kind == ACC_PREFETCH;
  endsequence
  sequence s_ld_miss;
    acc_valid && acc_ready && acc_kind == ACC_SPEC_LOAD && (xlat_miss || l2_miss);
  endsequence

  property p_normal;
    s_pf ##0 discard_mode == DISCARD_NORMAL |=> pf_issue_r && !pf_discard_r;
  endproperty
  a_normal: assert property (p_normal) else $error("normal prefetch not issued");

  property p_fault;
    pf_fault_r |-> $past(acc_fault_kind) && pf_issue_r;
  endproperty
  a_fault: assert property (p_fault) else $error("fault from non-fault prefetch");

  property p_drop_xlat;
    s_pf ##0 discard_mode == DISCARD_ON_XLAT_MISS && xlat_miss
      |=> pf_discard_r && !walk_start_r;
  endproperty
  a_drop_xlat: assert property (p_drop_xlat) else $error("xlat miss not dropped");

  property p_drop_l2;
    s_pf ##0 discard_mode == DISCARD_ON_XLAT_OR_L2_MISS && l2_miss |=> pf_discard_r;
  endproperty
  a_drop_l2: assert property (p_drop_l2) else $error("l2 miss not dropped");

  property p_drop_queue;
    s_pf ##0 discard_mode == DISCARD_ANY && pfq_near_full |=> pf_discard_r && !pf_issue_r;
  endproperty
  a_drop_queue: assert property (p_drop_queue) else $error("queue risk not dropped");

  property p_cnt_xlat;
    evt.ev[`EV_DISC_XLAT] |=> cnt_discard_xlat_miss == $past(cnt_discard_xlat_miss) + 1'b1;
  endproperty
  a_cnt_xlat: assert property (p_cnt_xlat) else $error("xlat discard not counted");

  property p_walk_defer;
    s_pf ##0 !discard && xlat_miss && !pipe_block
      |=> walk_start_r && pf_enqueue_r && !pipe_stall;
  endproperty
  a_walk_defer: assert property (p_walk_defer) else $error("deferred walk wrong");

  property p_ld_defer;
    s_ld_miss ##0 !pipe_block && defer_allowed |=> spec_defer_r && !use_stall;
  endproperty
  a_ld_defer: assert property (p_ld_defer) else $error("load not deferred");

  property p_walk_block;
    s_pf ##0 !discard && xlat_miss && pipe_block |=> pipe_stall && !pf_enqueue_r;
  endproperty
  a_walk_block: assert property (p_walk_block) else $error("blocking walk no stall");

  property p_stall_hold;
    pipe_stall && !walk_done |=> pipe_stall;
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("stall ended early");

  property p_ld_block;
    s_ld_miss ##0 pipe_block |=> use_stall && !spec_defer_r;
  endproperty
  a_ld_block: assert property (p_ld_block) else $error("blocked load deferred");

  property p_use_release;
    use_stall && load_data_ret |=> !use_stall && acc_ready;
  endproperty
  a_use_release: assert property (p_use_release) else $error("use stall stuck");

  property p_fill_excl;
    is_rd && llc_fill && !bias_shared && !other_cache_holds |=> fill_excl_r && !fill_shared_r;
  endproperty
  a_fill_excl: assert property (p_fill_excl) else $error("exclusive fill missed");

  property p_fill_shared;
    is_rd && llc_fill && bias_shared |=> fill_shared_r && !fill_excl_r;
  endproperty
  a_fill_shared: assert property (p_fill_shared) else $error("shared fill missed");

  property p_capture;
    take && capture_sel && acc_legacy
      |=> cap_valid_r && cap_hint_r == $past(hint) && cap_idx_r == {1'b0, $past(acc_temporal)};
  endproperty
  a_capture: assert property (p_capture) else $error("capture hint wrong");

  property p_push_default;
    call_push && !ctx_flush ##1 !hint_wr_en && !call_push && !ret_pop && !ctx_flush
      |=> hint_rd_data_r == {5'h00, default_hint($past(hint_rd_idx))};
  endproperty
  a_push_default: assert property (p_push_default) else $error("push not default");

endmodule : data_access_hint_policy

`default_nettype wire

// [logic/hint_defs.svh]
// Constants for the data access hint policy block
// Assumes inclusion by bare name from the hint package and modules
`ifndef HINT_DEFS_SVH
`define HINT_DEFS_SVH

`define HINT_W 11
`define HINT_SW_W 16
`define NUM_HINT_REGS 8
`define STACK_DEPTH 7
`define CNT_W 16
`define ADDR_W 64

`define DROP_LSB 7
`define DROP_MSB 8
`define PIPE_BIT 9
`define BIAS_BIT 10

`define HINT_DEF0 11'h200
`define HINT_DEF1 11'h222
`define HINT_DEF2 11'h226
`define HINT_DEF3 11'h232
`define HINT_DEF4 11'h000
`define HINT_DEF5 11'h022
`define HINT_DEF6 11'h04a
`define HINT_DEF7 11'h07a

`define EV_DISC_XLAT 0
`define EV_DISC_L2 1
`define EV_DISC_FIRST 2
`define EV_L2_DEFER 3
`define EV_LOAD_STALL 4
`define EV_SHARED_FILL 5
`define NUM_EV 6

`endif

// [logic/hint_pkg.sv]
// Types and default hint values for the data access hint policy
// Assumes hint_defs.svh is on the include path
`include "hint_defs.svh"
`default_nettype none

package hint_pkg;

  typedef logic [`HINT_W-1:0] hint_t;

  typedef enum logic [1:0]
  {
    DISCARD_NORMAL = 2'b00,
    DISCARD_ON_XLAT_MISS = 2'b01,
    DISCARD_ON_XLAT_OR_L2_MISS = 2'b10,
    DISCARD_ANY = 2'b11
  } prefetch_discard_field_t;

  typedef enum logic [1:0]
  {
    ACC_PREFETCH = 2'b00,
    ACC_SPEC_LOAD = 2'b01,
    ACC_DATA_READ = 2'b10,
    ACC_OTHER = 2'b11
  } acc_kind_t;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_WALK = 2'b01,
    ST_USE = 2'b10
  } pipe_state_t;

  function automatic hint_t default_hint(input logic [2:0] idx);
    case (idx)
      3'h0: default_hint = `HINT_DEF0;
      3'h1: default_hint = `HINT_DEF1;
      3'h2: default_hint = `HINT_DEF2;
      3'h3: default_hint = `HINT_DEF3;
      3'h4: default_hint = `HINT_DEF4;
      3'h5: default_hint = `HINT_DEF5;
      3'h6: default_hint = `HINT_DEF6;
      default: default_hint = `HINT_DEF7;
    endcase
  endfunction : default_hint

endpackage : hint_pkg

`default_nettype wire

// [logic/hint_evt_if.sv]
// Event pulse carrier from the policy logic to the event counters
// Assumes one clock; each bit is a one-cycle pulse
`include "hint_defs.svh"
`default_nettype none

interface hint_evt_if;
  logic [`NUM_EV-1:0] ev;
  modport src (output ev);
  modport sink (input ev);
endinterface : hint_evt_if

`default_nettype wire

// [logic/hint_stack.sv]
// Frame stack of access hint registers with default reload
// Assumes push, pop, flush and write are single-cycle pulses
`include "hint_defs.svh"
`default_nettype none

module hint_stack
  import hint_pkg::*;
#(
  parameter int DEPTH = `STACK_DEPTH
)
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic push,
  input wire logic pop,
  input wire logic flush,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire hint_t wr_data,
  input wire logic [2:0] a_idx,
  output hint_t a_hint,
  input wire logic [2:0] b_idx,
  output hint_t b_hint,
  output logic [$clog2(DEPTH):0] frames
);
  localparam int PW = $clog2(DEPTH);

  hint_t mem_r [DEPTH][`NUM_HINT_REGS];
  logic [PW-1:0] top_r;
  logic [PW:0] cnt_r;
  logic [PW-1:0] up_ptr;
  logic [PW-1:0] dn_ptr;

  function automatic logic [PW-1:0] step(input logic [PW-1:0] p, input logic up);
    if (up)
      step = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    else
      step = (p == '0) ? PW'(DEPTH - 1) : p - 1'b1;
  endfunction : step

  assign up_ptr = step(top_r, 1'b1);
  assign dn_ptr = step(top_r, 1'b0);
  assign a_hint = mem_r[top_r][a_idx];
  assign b_hint = mem_r[top_r][b_idx];
  assign frames = cnt_r;

  always_ff @(posedge ref_clk)
  begin
    if (srst || flush)
    begin
      top_r <= '0;
      cnt_r <= (PW+1)'(1);
      for (int f = 0; f < DEPTH; f++)
        for (int i = 0; i < `NUM_HINT_REGS; i++)
          mem_r[f][i] <= default_hint(3'(i));
    end
    else if (push)
    begin
      top_r <= up_ptr;
      if (cnt_r != (PW+1)'(DEPTH))
        cnt_r <= cnt_r + 1'b1;
      for (int i = 0; i < `NUM_HINT_REGS; i++)
        mem_r[up_ptr][i] <= default_hint(3'(i));
    end
    else if (pop)
    begin
      if (cnt_r > (PW+1)'(1))
      begin
        top_r <= dn_ptr;
        cnt_r <= cnt_r - 1'b1;
      end
      else
        for (int i = 0; i < `NUM_HINT_REGS; i++)
          mem_r[top_r][i] <= default_hint(3'(i));
    end
    else if (wr_en)
      mem_r[top_r][wr_idx] <= wr_data;
  end

endmodule : hint_stack

`default_nettype wire

// [logic/hint_counters.sv]
// Hint event counters, one per event pulse, wrapping
// Assumes event pulses come from logic on the same clock
`include "hint_defs.svh"
`default_nettype none

module hint_counters
#(
  parameter int CW = `CNT_W
)
(
  input wire logic ref_clk,
  input wire logic srst,
  hint_evt_if.sink evt,
  output logic [`NUM_EV-1:0][CW-1:0] count_r
);

  always_ff @(posedge ref_clk)
  begin
    for (int e = 0; e < `NUM_EV; e++)
      if (srst)
        count_r[e] <= '0;
      else if (evt.ev[e])
        count_r[e] <= count_r[e] + 1'b1;
  end

endmodule : hint_counters

`default_nettype wire

// [verif/far_side_model.sv]
// Far-side model: page walker and load data return for the hint policy
// Assumes walk_start_r and use_stall come from the policy on ref_clk
`default_nettype none

module far_side_model
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [3:0] lat,
  input wire logic walk_start_r,
  input wire logic use_stall,
  output logic walk_done,
  output logic load_data_ret
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] walk_cnt_r;
  logic [3:0] load_cnt_r;
  logic use_q_r;

  // Walk and load answers come lat+1 cycles after the request
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      walk_cnt_r <= 4'h0;
      load_cnt_r <= 4'h0;
      use_q_r <= 1'b0;
      walk_done <= 1'b0;
      load_data_ret <= 1'b0;
    end
    else
    begin
      use_q_r <= use_stall;
      walk_done <= (walk_cnt_r == 4'h1);
      load_data_ret <= (load_cnt_r == 4'h1);
      walk_cnt_r <= walk_start_r ? lat : walk_cnt_r - {3'h0, walk_cnt_r != 4'h0};
      load_cnt_r <= (use_stall && !use_q_r) ? lat : load_cnt_r - {3'h0, load_cnt_r != 4'h0};
    end
  end
endmodule : far_side_model

`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the data access hint policy
// Assumes the hint package, interface and design modules compile first
`default_nettype none

module testbench
  import hint_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk, srst, hint_wr_en, call_push, ret_pop, ctx_flush;
  logic [2:0] hint_wr_idx, hint_rd_idx, acc_hint_idx, cap_idx_r;
  logic [15:0] hint_wr_data, hint_rd_data_r;
  logic [3:0] frame_count, lat;
  logic acc_valid, acc_ready, acc_legacy, acc_fault, acc_fault_kind, capture_sel;
  acc_kind_t acc_kind;
  logic [1:0] acc_temporal;
  logic [63:0] acc_addr, cap_addr_r;
  logic xlat_miss, first_xlat_miss, l2_miss, pfq_near_full, defer_allowed;
  logic llc_fill, other_cache_holds, walk_done, load_data_ret;
  logic pf_discard_r, pf_issue_r, pf_enqueue_r, pf_fault_r, walk_start_r, pipe_stall;
  logic spec_defer_r, use_stall, fill_excl_r, fill_shared_r, cap_valid_r;
  hint_t cap_hint_r;
  logic [15:0] cnt_discard_xlat_miss, cnt_discard_l2_miss, cnt_discard_first_xlat_miss;
  logic [15:0] cnt_l2_defer, cnt_spec_load_stalled, cnt_shared_fill;
  logic [9:0] o;
  logic d;
  logic [15:0] ex, ef, el2, ed, est, esf;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  // Default encodings built from the per-field default tables
  logic [15:0] dflt [8] = '{16'h0200, 16'h0222, 16'h0226, 16'h0232,
                            16'h0000, 16'h0022, 16'h004a, 16'h007a};

  data_access_hint_policy dut
  (
    .ref_clk, .srst, .hint_wr_en, .hint_wr_idx, .hint_wr_data, .hint_rd_idx,
    .hint_rd_data_r, .call_push, .ret_pop, .ctx_flush, .frame_count, .acc_valid,
    .acc_ready, .acc_kind, .acc_legacy, .acc_temporal, .acc_hint_idx, .acc_addr,
    .acc_fault, .acc_fault_kind, .capture_sel, .xlat_miss, .first_xlat_miss, .l2_miss,
    .pfq_near_full, .defer_allowed, .llc_fill, .other_cache_holds, .walk_done,
    .load_data_ret, .pf_discard_r, .pf_issue_r, .pf_enqueue_r, .pf_fault_r,
    .walk_start_r, .pipe_stall, .spec_defer_r, .use_stall, .fill_excl_r,
    .fill_shared_r, .cap_valid_r, .cap_addr_r, .cap_hint_r, .cap_idx_r,
    .cnt_discard_xlat_miss, .cnt_discard_l2_miss, .cnt_discard_first_xlat_miss,
    .cnt_l2_defer, .cnt_spec_load_stalled, .cnt_shared_fill
  );

  far_side_model mem_side
  (
    .ref_clk, .srst, .lat, .walk_start_r, .use_stall, .walk_done, .load_data_ret
  );

  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] idx, input logic [15:0] dat);
    @(negedge ref_clk);
    hint_wr_en = 1'b1;
    hint_wr_idx = idx;
    hint_wr_data = dat;
    @(negedge ref_clk);
    hint_wr_en = 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] idx, input logic [15:0] exp);
    @(negedge ref_clk);
    hint_rd_idx = idx;
    @(negedge ref_clk);
    chk(hint_rd_data_r, exp);
  endtask : rd

  task automatic pulse(input logic [2:0] p);
    @(negedge ref_clk);
    {ctx_flush, call_push, ret_pop} = p;
    @(negedge ref_clk);
    {ctx_flush, call_push, ret_pop} = 3'h0;
  endtask : pulse

  // One access; o holds the decision outputs of the cycle after it is taken
  task automatic acc(input acc_kind_t k, input logic [2:0] idx, input logic leg,
                     input logic [6:0] q, input logic [1:0] f);
    int w;
    w = 0;
    @(negedge ref_clk);
    while (acc_ready !== 1'b1 && w < 100)
    begin
      @(negedge ref_clk);
      w++;
    end
    acc_valid = 1'b1;
    acc_kind = k;
    acc_hint_idx = {idx[2] ^ leg, idx[1:0]};
    acc_legacy = leg;
    acc_temporal = idx[1:0];
    capture_sel = leg;
    acc_addr = {48'h0, 13'h1ab0, idx};
    {xlat_miss, first_xlat_miss, l2_miss, pfq_near_full, defer_allowed, llc_fill,
     other_cache_holds} = q;
    {acc_fault, acc_fault_kind} = f;
    @(negedge ref_clk);
    acc_valid = 1'b0;
    {xlat_miss, first_xlat_miss, l2_miss, pfq_near_full, defer_allowed, llc_fill,
     other_cache_holds} = 7'h0;
    o = {pf_discard_r, pf_issue_r, pf_enqueue_r, pf_fault_r, walk_start_r, spec_defer_r,
         fill_excl_r, fill_shared_r, pipe_stall, use_stall};
  endtask : acc

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      results();
    end
  end

  initial
  begin
    {hint_wr_en, call_push, ret_pop, ctx_flush, acc_valid, acc_legacy, capture_sel} = '0;
    {hint_wr_idx, hint_rd_idx, acc_hint_idx, acc_temporal, hint_wr_data} = '0;
    {xlat_miss, first_xlat_miss, l2_miss, pfq_near_full, defer_allowed} = '0;
    {llc_fill, other_cache_holds, acc_fault, acc_fault_kind, acc_addr} = '0;
    {ex, ef, el2, ed, est, esf} = '0;
    acc_kind = ACC_PREFETCH;
    lat = 4'h1;
    srst = 1'b1;
    repeat (8) @(negedge ref_clk);
    srst = 1'b0;
    for (int i = 0; i < 8; i++)
      rd(i[2:0], dflt[i]);
    chk(16'(frame_count), 16'h1);
    wr(3'h5, 16'hffff);
    rd(3'h5, 16'h07ff);
    wr(3'h0, 16'h0180);
    pulse(3'b010);
    rd(3'h0, 16'h0200);
    rd(3'h5, 16'h0022);
    chk(16'(frame_count), 16'h2);
    pulse(3'b001);
    rd(3'h0, 16'h0180);
    chk(16'(frame_count), 16'h1);
    wr(3'h2, 16'h0180);
    pulse(3'b010);
    pulse(3'b100);
    rd(3'h2, 16'h0226);
    chk(16'(frame_count), 16'h1);
    @(negedge ref_clk);
    srst = 1'b1;
    @(negedge ref_clk);
    srst = 1'b0;
    rd(3'h0, 16'h0200);
    rd(3'h5, 16'h0022);
    for (int i = 0; i < 4; i++)
    begin
      acc(ACC_DATA_READ, i[2:0], 1'b1, 7'h00, 2'h0);
      chk(16'(cap_idx_r), 16'(i));
      chk(16'(cap_hint_r), dflt[i]);
      chk(16'({cap_valid_r, cap_addr_r[15:0] == {13'h1ab0, i[2:0]}}), 16'h3);
    end
    acc(ACC_PREFETCH, 3'h0, 1'b0, 7'h00, 2'b10);
    chk(16'(o[9:6]), 16'h4);
    acc(ACC_PREFETCH, 3'h0, 1'b0, 7'h00, 2'b11);
    chk(16'(o[6]), 16'h1);
    acc(ACC_PREFETCH, 3'h4, 1'b0, 7'h40, 2'h0);
    chk(16'({o[7], o[5], o[1]}), 16'h6);
    for (int f = 0; f < 4; f++)
    begin
      wr(3'h4, {7'h0, f[1:0], 7'h0});
      for (int c = 0; c < 4; c++)
      begin
        acc(ACC_PREFETCH, 3'h4, 1'b0, 7'h40 >> c, 2'h0);
        d = (c == 0 && f >= 1) || (c == 2 && f >= 2) || (c[0] && f == 3);
        chk(16'(o[9:8]), 16'({d, !d}));
        ex += 16'(d && c == 0);
        ef += 16'(d && c == 1);
        el2 += 16'(d && c == 2);
      end
    end
    wr(3'h4, 16'h0000);
    acc(ACC_SPEC_LOAD, 3'h4, 1'b0, 7'h14, 2'h0);
    chk(16'({o[4], o[0]}), 16'h2);
    acc(ACC_SPEC_LOAD, 3'h4, 1'b0, 7'h44, 2'h0);
    chk(16'({o[4], o[0]}), 16'h2);
    ed = 16'h1;
    for (int j = 0; j < 4; j++)
    begin
      lat = j[0] ? 4'h6 : 4'h1;
      acc(j[1] ? ACC_SPEC_LOAD : ACC_PREFETCH, 3'h0, 1'b0, 7'h44, 2'h0);
      chk(16'(j[1] ? {o[4], o[0]} : {o[5], o[1]}), j[1] ? 16'h1 : 16'h3);
      chk(16'(acc_ready), 16'h0);
      est += 16'(j[1]);
      n = 0;
      while ((pipe_stall | use_stall) === 1'b1 && n < 50)
      begin
        @(negedge ref_clk);
        n++;
      end
      chk(16'(n), 16'(lat + 2));
    end
    acc(ACC_DATA_READ, 3'h0, 1'b0, 7'h02, 2'h0);
    chk(16'(o[3:2]), 16'h2);
    acc(ACC_DATA_READ, 3'h0, 1'b0, 7'h03, 2'h0);
    chk(16'(o[3:2]), 16'h1);
    wr(3'h1, 16'h0622);
    acc(ACC_DATA_READ, 3'h1, 1'b0, 7'h02, 2'h0);
    chk(16'(o[3:2]), 16'h1);
    esf = 16'h1;
    repeat (2) @(negedge ref_clk);
    chk(cnt_discard_xlat_miss, ex);
    chk(cnt_discard_l2_miss, el2);
    chk(cnt_discard_first_xlat_miss, ef);
    chk(cnt_l2_defer, ed);
    chk(cnt_spec_load_stalled, est);
    chk(cnt_shared_fill, esf);
    results();
  end
endmodule : testbench

`default_nettype wire
